//--- ebp_pkg.sv
// Shared constants for the external bus and port pin block
package ebp_pkg;

  // Register offsets
  localparam logic [15:0] OFS_PORT_A_VALUE = 16'h1000;
  localparam logic [15:0] OFS_PORT_A_DIRECTION = 16'h1001;
  localparam logic [15:0] OFS_PORT_G_VALUE = 16'h1002;
  localparam logic [15:0] OFS_PORT_G_DIRECTION = 16'h1003;
  localparam logic [15:0] OFS_PORT_B_VALUE = 16'h1004;
  localparam logic [15:0] OFS_PORT_F_VALUE = 16'h1005;
  localparam logic [15:0] OFS_PORT_C_VALUE = 16'h1006;
  localparam logic [15:0] OFS_PORT_C_DIRECTION = 16'h1007;
  localparam logic [15:0] OFS_PORT_D_VALUE = 16'h1008;
  localparam logic [15:0] OFS_PORT_D_DIRECTION = 16'h1009;
  localparam logic [15:0] OFS_PORT_E_VALUE = 16'h100a;
  localparam logic [15:0] OFS_BUS_CTRL = 16'h1040;
  localparam logic [15:0] OFS_BUS_STATUS = 16'h1041;

  // Field positions
  localparam int unsigned CTRL_CS_EN_BIT = 0;
  localparam int unsigned STAT_MODE_LSB = 0;
  localparam int unsigned STAT_STRETCH_BIT = 2;
  localparam int unsigned STAT_BUSY_BIT = 3;
  localparam int unsigned PORT_D_WIDTH = 6;

  // Values after reset
  localparam logic [7:0] PORT_RESET_VAL = 8'h00;
  localparam logic [7:0] DIR_RESET_VAL = 8'h00;
  localparam logic [7:0] CTRL_RESET_VAL = 8'h00;

  // Cycle counts in oscillator cycles
  localparam int unsigned OSC_DIV = 4;
  localparam int unsigned E_LOW_CYCLES = OSC_DIV / 2;
  localparam int unsigned E_HIGH_CYCLES = 2;
  localparam int unsigned E_STRETCH_CYCLES = 4;
  localparam int unsigned INSTR_MARK_CYCLES = OSC_DIV;
  localparam int unsigned RST_PULL_CYCLES_DEF = 16;

  // Operating mode, latched as {boot_sel_b, boot_sel_a}
  typedef enum logic [1:0] {
    EBP_MODE_BOOT = 2'b00,
    EBP_MODE_TEST = 2'b01,
    EBP_MODE_SINGLE = 2'b10,
    EBP_MODE_EXPANDED = 2'b11
  } ebp_mode_t;

  typedef enum logic [1:0] {
    EBP_BUS_IDLE,
    EBP_BUS_ADDR,
    EBP_BUS_DATA
  } ebp_bus_state_t;

endpackage

//--- ebp_eclk_gen.sv
// Bus-phase clock generator with wait stretching
`timescale 1ns/1ps
module ebp_eclk_gen (
  input wire logic clk_sys_i, // Oscillator clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic wait_i, // Stretch request
  output logic e_clk_o, // Bus-phase clock
  output logic strobe_n_o, // Inverted bus-phase clock
  output logic rise_o, // First cycle of high phase
  output logic fall_o, // First cycle of low phase
  output logic stretch_o // Current high phase is stretched
);
  import ebp_pkg::*;

  logic [2:0] cnt_r;
  logic [2:0] hi_len_r;

  // Low phase two cycles, high phase two or stretched
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_r <= 3'h0;
      e_clk_o <= 1'b0;
      strobe_n_o <= 1'b1;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      hi_len_r <= 3'(E_HIGH_CYCLES);
      stretch_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (!e_clk_o && cnt_r == 3'(E_LOW_CYCLES - 1)) begin
        cnt_r <= 3'h0;
        e_clk_o <= 1'b1;
        strobe_n_o <= 1'b0;
        rise_o <= 1'b1;
        // Wait sampled at the rising edge
        hi_len_r <= wait_i ? 3'(E_STRETCH_CYCLES) : 3'(E_HIGH_CYCLES);
        stretch_o <= wait_i;
      end else if (e_clk_o && cnt_r == hi_len_r - 3'h1) begin
        cnt_r <= 3'h0;
        e_clk_o <= 1'b0;
        strobe_n_o <= 1'b1;
        fall_o <= 1'b1;
        stretch_o <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

endmodule // ebp_eclk_gen

//--- ebp_bus_ports.sv
// External bus sequencer, mode latch and parallel port pins
//
// Operation
// - Bus clock is oscillator divided by four
// - Address in low phase, data in high
// - Data strobe is inverted bus clock
// - Wait high at rise stretches four cycles
// - Wait low: clock falls two cycles later
// - Reset pin pulled low on failures
// - Boot pins latched during reset select mode
// - First boot pin marks instruction start
// - Read/write output shows transfer direction
// - Port A bidirectional, inputs after reset
// - Port B outputs or upper address
// - Port C I/O or data bus
// - Port D six pins, I/O or serial
// - Port F outputs or lower address
// - Port G upper pins carry chip selects
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module ebp_bus_ports #(
  parameter int unsigned RST_PULL_CYCLES = ebp_pkg::RST_PULL_CYCLES_DEF
) (
  input wire logic clk_sys_i, // Oscillator clock, four times bus rate
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [15:0] reg_addr_i, // Register address
  input wire logic [7:0] reg_wdata_i, // Register write data
  input wire logic reg_wr_i, // Register write strobe
  input wire logic reg_rd_i, // Register read strobe
  output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
  input wire logic ext_req_i, // External access request pulse
  input wire logic ext_we_i, // Request is a write
  input wire logic [15:0] ext_addr_i, // External address
  input wire logic [7:0] ext_wdata_i, // External write data
  output logic [7:0] ext_rdata_o, // External read data
  output logic ext_done_o, // Access finished pulse
  output logic ext_busy_o, // Access pending or running
  input wire logic instr_start_i, // Core starts an instruction
  input wire logic clk_mon_fail_i, // Clock monitor failure
  input wire logic watchdog_timer_fail_i, // Watchdog timeout
  input wire logic wait_i, // Bus stretch input
  output logic e_clk_o, // Bus-phase clock
  output logic inverted_phase_strobe_o, // Data strobe
  output logic rw_o, // High read, low write
  output logic reset_pin_o, // Reset pin drive value
  output logic reset_pin_oe_n_o, // Reset pin enable, low drives
  input wire logic boot_sel_a_i, // Boot select A pin level
  input wire logic boot_sel_b_i, // Boot select B pin level
  output logic instr_start_n_o, // Instruction mark drive value
  output logic instr_start_n_oe_n_o, // Instruction mark enable, low drives
  input wire logic [7:0] port_a_pins_i, // Port A pin levels
  output logic [7:0] port_a_pins_o, // Port A drive values
  output logic [7:0] port_a_pins_oe_n_o, // Port A enables, low drives
  output logic [7:0] port_b_pins_o, // Port B outputs
  input wire logic [7:0] port_c_pins_i, // Port C pin levels
  output logic [7:0] port_c_pins_o, // Port C drive values
  output logic [7:0] port_c_pins_oe_n_o, // Port C enables, low drives
  input wire logic [5:0] port_d_pins_i, // Port D pin levels
  output logic [5:0] port_d_pins_o, // Port D drive values
  output logic [5:0] port_d_pins_oe_n_o, // Port D enables, low drives
  input wire logic [5:0] serial_d_en_i, // Serial unit owns pin
  input wire logic [5:0] serial_d_out_i, // Serial unit drive value
  input wire logic [5:0] serial_d_drive_i, // Serial unit drives pin
  input wire logic [7:0] port_e_pins_i, // Port E pin levels
  output logic [7:0] port_f_pins_o, // Port F outputs
  input wire logic [7:0] port_g_pins_i, // Port G pin levels
  output logic [7:0] port_g_pins_o, // Port G drive values
  output logic [7:0] port_g_pins_oe_n_o, // Port G enables, low drives
  input wire logic [3:0] chip_sel_i, // Chip selects from decoder
  output logic [1:0] mode_o // Latched operating mode
);
  import ebp_pkg::*;

  logic [7:0] port_a_value_r;
  logic [7:0] port_a_direction_r;
  logic [7:0] port_b_value_r;
  logic [7:0] port_c_value_r;
  logic [7:0] port_c_direction_r;
  logic [5:0] port_d_value_r;
  logic [5:0] port_d_direction_r;
  logic [7:0] port_f_value_r;
  logic [7:0] port_g_value_r;
  logic [7:0] port_g_direction_r;
  logic [7:0] ctrl_r;
  ebp_mode_t mode_r;
  ebp_bus_state_t bus_r;
  logic pend_r;
  logic we_r;
  logic [15:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rd_nxt;
  logic [7:0] port_d_rd;
  logic [7:0] port_d_dir_rd;
  logic [$clog2(RST_PULL_CYCLES + 1)-1:0] pull_cnt_r;
  logic [2:0] mark_cnt_r;
  logic [1:0] hi_left_r;
  logic e_rise;
  logic e_fall;
  logic e_stretch;
  logic expanded;
  logic cs_en;
  logic drive_data;

  assign expanded = mode_r[0];
  assign cs_en = ctrl_r[CTRL_CS_EN_BIT];
  assign drive_data = expanded && we_r && e_clk_o &&
                      (e_rise ? bus_r == EBP_BUS_ADDR :
                                bus_r == EBP_BUS_DATA && hi_left_r != 2'h0);
  assign port_d_rd = {2'b00, (port_d_direction_r & port_d_value_r) |
                     (~port_d_direction_r & port_d_pins_i)};
  assign port_d_dir_rd = {2'b00, port_d_direction_r};

  ebp_eclk_gen u_eclk (
    .clk_sys_i (clk_sys_i),
    .rst_n_i (rst_n_i),
    .wait_i (wait_i),
    .e_clk_o (e_clk_o),
    .strobe_n_o (inverted_phase_strobe_o),
    .rise_o (e_rise),
    .fall_o (e_fall),
    .stretch_o (e_stretch)
  );

  // Mode pins sampled while reset is held
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mode_r <= ebp_mode_t'({boot_sel_b_i, boot_sel_a_i});
    end
  end

  assign mode_o = mode_r;

  // Register writes
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      port_a_value_r <= PORT_RESET_VAL;
      port_a_direction_r <= DIR_RESET_VAL;
      port_b_value_r <= PORT_RESET_VAL;
      port_c_value_r <= PORT_RESET_VAL;
      port_c_direction_r <= DIR_RESET_VAL;
      port_d_value_r <= PORT_RESET_VAL[5:0];
      port_d_direction_r <= DIR_RESET_VAL[5:0];
      port_f_value_r <= PORT_RESET_VAL;
      port_g_value_r <= PORT_RESET_VAL;
      port_g_direction_r <= DIR_RESET_VAL;
      ctrl_r <= CTRL_RESET_VAL;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFS_PORT_A_VALUE: port_a_value_r <= reg_wdata_i;
        OFS_PORT_A_DIRECTION: port_a_direction_r <= reg_wdata_i;
        OFS_PORT_B_VALUE: port_b_value_r <= reg_wdata_i;
        OFS_PORT_C_VALUE: port_c_value_r <= reg_wdata_i;
        OFS_PORT_C_DIRECTION: port_c_direction_r <= reg_wdata_i;
        OFS_PORT_D_VALUE: port_d_value_r <= reg_wdata_i[5:0];
        OFS_PORT_D_DIRECTION: port_d_direction_r <= reg_wdata_i[5:0];
        OFS_PORT_F_VALUE: port_f_value_r <= reg_wdata_i;
        OFS_PORT_G_VALUE: port_g_value_r <= reg_wdata_i;
        OFS_PORT_G_DIRECTION: port_g_direction_r <= reg_wdata_i;
        OFS_BUS_CTRL: ctrl_r <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Read mux; output bits read the latch, input bits the pin
  always_comb begin
    rd_nxt = 8'h00;
    unique case (reg_addr_i)
      OFS_PORT_A_VALUE: rd_nxt = (port_a_direction_r & port_a_value_r) |
                                 (~port_a_direction_r & port_a_pins_i);
      OFS_PORT_A_DIRECTION: rd_nxt = port_a_direction_r;
      OFS_PORT_B_VALUE: rd_nxt = port_b_value_r;
      OFS_PORT_C_VALUE: rd_nxt = (port_c_direction_r & port_c_value_r) |
                                 (~port_c_direction_r & port_c_pins_i);
      OFS_PORT_C_DIRECTION: rd_nxt = port_c_direction_r;
      OFS_PORT_D_VALUE: rd_nxt = port_d_rd;
      OFS_PORT_D_DIRECTION: rd_nxt = port_d_dir_rd;
      OFS_PORT_E_VALUE: rd_nxt = port_e_pins_i;
      OFS_PORT_F_VALUE: rd_nxt = port_f_value_r;
      OFS_PORT_G_VALUE: rd_nxt = (port_g_direction_r & port_g_value_r) |
                                 (~port_g_direction_r & port_g_pins_i);
      OFS_PORT_G_DIRECTION: rd_nxt = port_g_direction_r;
      OFS_BUS_CTRL: rd_nxt = ctrl_r;
      OFS_BUS_STATUS: begin
        rd_nxt[STAT_MODE_LSB +: 2] = mode_r;
        rd_nxt[STAT_STRETCH_BIT] = e_stretch;
        rd_nxt[STAT_BUSY_BIT] = ext_busy_o;
      end
      default: rd_nxt = 8'h00;
    endcase
  end

  // Read data stands one cycle only
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_nxt : 8'h00;
    end
  end

  // External bus sequencer, one access per bus cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bus_r <= EBP_BUS_IDLE;
      hi_left_r <= 2'h0;
      pend_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
      ext_rdata_o <= 8'h00;
      ext_done_o <= 1'b0;
      ext_busy_o <= 1'b0;
    end else begin
      ext_done_o <= 1'b0;
      hi_left_r <= e_rise && e_stretch ? 2'(E_STRETCH_CYCLES - E_HIGH_CYCLES) :
                   hi_left_r - 2'(hi_left_r != 2'h0);
      if (ext_req_i && !ext_busy_o) begin
        pend_r <= 1'b1;
        ext_busy_o <= 1'b1;
        we_r <= ext_we_i;
        addr_r <= ext_addr_i;
        wdata_r <= ext_wdata_i;
      end else if (pend_r && !expanded) begin
        // No external bus in single-chip modes
        pend_r <= 1'b0;
        ext_busy_o <= 1'b0;
        ext_done_o <= 1'b1;
        ext_rdata_o <= 8'h00;
      end else begin
        unique case (bus_r)
          EBP_BUS_IDLE: begin
            if (pend_r && e_fall) begin
              pend_r <= 1'b0;
              bus_r <= EBP_BUS_ADDR;
            end
          end
          EBP_BUS_ADDR: begin
            if (e_rise) begin
              bus_r <= EBP_BUS_DATA;
            end
          end
          EBP_BUS_DATA: begin
            if (e_fall) begin
              bus_r <= EBP_BUS_IDLE;
              ext_busy_o <= 1'b0;
              ext_done_o <= 1'b1;
              ext_rdata_o <= we_r ? 8'h00 : port_c_pins_i;
            end
          end
          default: bus_r <= EBP_BUS_IDLE;
        endcase
      end
    end
  end

  // Direction and address outputs
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rw_o <= 1'b1;
      port_b_pins_o <= 8'h00;
      port_f_pins_o <= 8'h00;
    end else begin
      rw_o <= !(expanded && bus_r != EBP_BUS_IDLE && we_r);
      port_b_pins_o <= expanded ? addr_r[15:8] : port_b_value_r;
      port_f_pins_o <= expanded ? addr_r[7:0] : port_f_value_r;
    end
  end

  // Per-bit pin drivers
  for (genvar i = 0; i < 8; i++) begin : g_pin
    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
        port_a_pins_o[i] <= 1'b0;
        port_a_pins_oe_n_o[i] <= 1'b1;
        port_c_pins_o[i] <= 1'b0;
        port_c_pins_oe_n_o[i] <= 1'b1;
      end else begin
        port_a_pins_o[i] <= port_a_value_r[i];
        port_a_pins_oe_n_o[i] <= !port_a_direction_r[i];
        if (expanded) begin
          port_c_pins_o[i] <= wdata_r[i];
          port_c_pins_oe_n_o[i] <= !drive_data;
        end else begin
          port_c_pins_o[i] <= port_c_value_r[i];
          port_c_pins_oe_n_o[i] <= !port_c_direction_r[i];
        end
      end
    end
    if (i >= 4) begin : g_cs
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          port_g_pins_o[i] <= 1'b0;
          port_g_pins_oe_n_o[i] <= 1'b1;
        end else if (cs_en) begin
          port_g_pins_o[i] <= chip_sel_i[i-4];
          port_g_pins_oe_n_o[i] <= 1'b0;
        end else begin
          port_g_pins_o[i] <= port_g_value_r[i];
          port_g_pins_oe_n_o[i] <= !port_g_direction_r[i];
        end
      end
    end else begin : g_gpio
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          port_g_pins_o[i] <= 1'b0;
          port_g_pins_oe_n_o[i] <= 1'b1;
        end else begin
          port_g_pins_o[i] <= port_g_value_r[i];
          port_g_pins_oe_n_o[i] <= !port_g_direction_r[i];
        end
      end
    end
    if (i < PORT_D_WIDTH) begin : g_pd
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          port_d_pins_o[i] <= 1'b0;
          port_d_pins_oe_n_o[i] <= 1'b1;
        end else if (serial_d_en_i[i]) begin
          port_d_pins_o[i] <= serial_d_out_i[i];
          port_d_pins_oe_n_o[i] <= !serial_d_drive_i[i];
        end else begin
          port_d_pins_o[i] <= port_d_value_r[i];
          port_d_pins_oe_n_o[i] <= !port_d_direction_r[i];
        end
      end
    end
  end

  // Reset pin pulled low for a minimum time on any failure
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pull_cnt_r <= '0;
      reset_pin_o <= 1'b0;
      reset_pin_oe_n_o <= 1'b1;
    end else begin
      reset_pin_o <= 1'b0;
      if (clk_mon_fail_i || watchdog_timer_fail_i) begin
        pull_cnt_r <= ($bits(pull_cnt_r))'(RST_PULL_CYCLES);
        reset_pin_oe_n_o <= 1'b0;
      end else if (pull_cnt_r != '0) begin
        pull_cnt_r <= pull_cnt_r - 1'b1;
        reset_pin_oe_n_o <= (pull_cnt_r == ($bits(pull_cnt_r))'(1));
      end else begin
        reset_pin_oe_n_o <= 1'b1;
      end
    end
  end

  // Boot select A becomes open-drain instruction mark after reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mark_cnt_r <= 3'h0;
      instr_start_n_o <= 1'b0;
      instr_start_n_oe_n_o <= 1'b1;
    end else begin
      instr_start_n_o <= 1'b0;
      if (instr_start_i) begin
        mark_cnt_r <= 3'(INSTR_MARK_CYCLES - 1);
        instr_start_n_oe_n_o <= 1'b0;
      end else if (mark_cnt_r != 3'h0) begin
        mark_cnt_r <= mark_cnt_r - 3'h1;
        instr_start_n_oe_n_o <= 1'b0;
      end else begin
        instr_start_n_oe_n_o <= 1'b1;
      end
    end
  end

endmodule // ebp_bus_ports

//--- ebp_bus_ports_monitor.sv
// Assertion checker for the external bus and port pin block
`timescale 1ns/1ps
module ebp_bus_ports_monitor (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic wait_i, // Stretch input
  input wire logic e_clk_o, // Bus-phase clock
  input wire logic inverted_phase_strobe_o, // Data strobe
  input wire logic rw_o, // Transfer direction
  input wire logic ext_busy_o, // Access running
  input wire logic ext_done_o, // Access finished
  input wire logic [7:0] port_c_pins_oe_n_o, // Data bus enables
  input wire logic [1:0] mode_o, // Latched mode
  input wire logic clk_mon_fail_i, // Clock monitor failure
  input wire logic watchdog_timer_fail_i, // Watchdog failure
  input wire logic reset_pin_oe_n_o, // Reset pin enable
  input wire logic instr_start_i, // Instruction begins
  input wire logic instr_start_n_oe_n_o // Instruction mark enable
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_strobe_inverse: assert property (inverted_phase_strobe_o == !e_clk_o)
    else $error("strobe is not the inverted bus clock");
  chk_low_two: assert property ($fell(e_clk_o) |=> !e_clk_o ##1 e_clk_o)
    else $error("bus clock low phase not two cycles");
  chk_high_normal: assert property ($rose(e_clk_o) && !$past(wait_i) |=> e_clk_o ##1 !e_clk_o)
    else $error("bus clock high phase not two cycles");
  chk_high_stretch: assert property ($rose(e_clk_o) && $past(wait_i) |-> e_clk_o[*4] ##1 !e_clk_o)
    else $error("stretched high phase not four cycles");
  chk_data_phase: assert property (mode_o[0] && !port_c_pins_oe_n_o[0] |-> e_clk_o)
    else $error("data bus driven outside high phase");
  chk_rw_write: assert property (mode_o[0] && !port_c_pins_oe_n_o[0] |-> !rw_o)
    else $error("data driven while direction shows read");
  chk_rw_idle: assert property (!ext_busy_o && !ext_done_o && !$past(ext_done_o) |-> rw_o)
    else $error("direction shows write while idle");
  chk_reset_pull: assert property (clk_mon_fail_i || watchdog_timer_fail_i |=> !reset_pin_oe_n_o)
    else $error("reset pin not pulled on failure");
  chk_instr_mark: assert property (instr_start_i |=> !instr_start_n_oe_n_o [*4])
    else $error("instruction mark shorter than four cycles");
  chk_mode_hold: assert property (rst_n_i && $past(rst_n_i) |-> $stable(mode_o))
    else $error("mode changed outside reset");
endmodule // ebp_bus_ports_monitor

bind ebp_bus_ports ebp_bus_ports_monitor u_mon (.clk_sys_i, .rst_n_i, .wait_i, .e_clk_o,
  .inverted_phase_strobe_o, .rw_o, .ext_busy_o, .ext_done_o, .port_c_pins_oe_n_o, .mode_o,
  .clk_mon_fail_i, .watchdog_timer_fail_i, .reset_pin_oe_n_o, .instr_start_i,
  .instr_start_n_oe_n_o);

//--- ebp_ext_mem.sv
// Behavioural external memory on the bus
`timescale 1ns/1ps
module ebp_ext_mem (
  input wire logic clk_sys_i, // Oscillator clock
  input wire logic e_clk_i, // Bus-phase clock
  input wire logic rw_i, // High read
  input wire logic [7:0] addr_i, // Low address lines
  input wire logic [7:0] data_i, // Data bus level
  input wire logic slow_i, // Answer slowly
  output logic [7:0] data_o, // Data to device
  output logic wait_o // Stretch request
);
  logic [7:0] mem_r [256];
  logic [7:0] last_r = 8'h00;
  logic [7:0] latch_r = 8'h00;
  logic e_r = 1'b0;
  logic drive;
  assign wait_o = slow_i;
  assign drive = rw_i && (e_clk_i || e_r);
  // Released bus shows inverse of last value
  assign data_o = drive ? mem_r[addr_i] : ~last_r;
  // Write data followed while E is high, stored once E has fallen
  always_ff @(posedge clk_sys_i) begin
    e_r <= e_clk_i;
    if (e_clk_i && !rw_i) begin
      latch_r <= data_i;
    end
    if (e_r && !e_clk_i && !rw_i) begin
      mem_r[addr_i] <= latch_r;
    end
    if (drive) begin
      last_r <= mem_r[addr_i];
    end
  end
endmodule // ebp_ext_mem

//--- ebp_bus_ports_tb.sv
// Self-checking testbench for the external bus and port pin block
`timescale 1ns/1ps
module ebp_bus_ports_tb;
  import ebp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr = 1'b0, rd = 1'b0, req = 1'b0, we = 1'b0, ins = 1'b0, cmf = 1'b0, wdf = 1'b0;
  logic slow = 1'b0, sa = 1'b1, sb = 1'b1;
  logic [15:0] ra = 16'h0000, ea = 16'h0000;
  logic [7:0] wd = 8'h00, ed = 8'h00, pa_x = 8'h00, pe = 8'h00;
  logic [5:0] sd_en = 6'h00, sd_out = 6'h00, sd_drv = 6'h00;
  logic [3:0] cs = 4'h0;
  logic [7:0] rdat, erd, pa_o, pa_oe, pa_i, pb, pc_o, pc_oe, pc_i, pf, pg_o, pg_oe, mem_d;
  logic [5:0] pd_o, pd_oe;
  logic [1:0] mode;
  logic done, busy, e_clk, strb, rw, rp, rp_oe, ip, ip_oe, wt;
  int fails = 0;
  int comparisons = 0;

  assign pa_i = (pa_oe & pa_x) | (~pa_oe & pa_o);
  assign pc_i = (pc_oe & mem_d) | (~pc_oe & pc_o);

  ebp_bus_ports #(.RST_PULL_CYCLES(2)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .ext_req_i(req), .ext_we_i(we), .ext_addr_i(ea), .ext_wdata_i(ed), .ext_rdata_o(erd),
    .ext_done_o(done), .ext_busy_o(busy), .instr_start_i(ins), .clk_mon_fail_i(cmf),
    .watchdog_timer_fail_i(wdf), .wait_i(wt), .e_clk_o(e_clk), .inverted_phase_strobe_o(strb),
    .rw_o(rw), .reset_pin_o(rp), .reset_pin_oe_n_o(rp_oe), .boot_sel_a_i(sa),
    .boot_sel_b_i(sb), .instr_start_n_o(ip), .instr_start_n_oe_n_o(ip_oe),
    .port_a_pins_i(pa_i), .port_a_pins_o(pa_o), .port_a_pins_oe_n_o(pa_oe), .port_b_pins_o(pb),
    .port_c_pins_i(pc_i), .port_c_pins_o(pc_o), .port_c_pins_oe_n_o(pc_oe),
    .port_d_pins_i((pd_oe & 6'h15) | (~pd_oe & pd_o)), .port_d_pins_o(pd_o),
    .port_d_pins_oe_n_o(pd_oe), .serial_d_en_i(sd_en), .serial_d_out_i(sd_out),
    .serial_d_drive_i(sd_drv), .port_e_pins_i(pe), .port_f_pins_o(pf),
    .port_g_pins_i(~pg_oe & pg_o), .port_g_pins_o(pg_o), .port_g_pins_oe_n_o(pg_oe),
    .chip_sel_i(cs), .mode_o(mode));

  ebp_ext_mem u_mem (.clk_sys_i(clk_sys_i), .e_clk_i(e_clk), .rw_i(rw), .addr_i(pf),
    .data_i(pc_i), .slow_i(slow), .data_o(mem_d), .wait_o(wt));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    rd <= 1'b1;
    ra <= a;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 chk(rdat, exp);
  endtask

  task automatic ext_acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                         input logic [7:0] exp, input logic is_rd);
    int n = 0;
    @(posedge clk_sys_i);
    req <= 1'b1;
    we <= w;
    ea <= a;
    ed <= d;
    @(posedge clk_sys_i);
    req <= 1'b0;
    #1;
    while (done !== 1'b1 && n < 40) begin
      pause(1);
      n++;
    end
    chk({7'h00, done}, 8'h01);
    if (is_rd) begin
      chk(erd, exp);
    end
  endtask

  task automatic do_reset(input logic b, input logic a);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    sb <= b;
    sa <= a;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    sb <= ~b;
    sa <= ~a;
    pause(1);
  endtask

  task automatic t_port_a();
    @(posedge clk_sys_i);
    pa_x <= 8'h3c;
    reg_wr(OFS_PORT_A_DIRECTION, 8'hf0);
    reg_wr(OFS_PORT_A_VALUE, 8'ha5);
    pause(1);
    chk(pa_oe, 8'h0f);
    chk(pa_o & 8'hf0, 8'ha0);
    reg_rd(OFS_PORT_A_VALUE, 8'hac);
    reg_rd(OFS_PORT_A_DIRECTION, 8'hf0);
  endtask

  task automatic t_ports_dg();
    @(posedge clk_sys_i);
    sd_en <= 6'h01;
    sd_out <= 6'h01;
    sd_drv <= 6'h01;
    cs <= 4'ha;
    reg_wr(OFS_PORT_D_DIRECTION, 8'hff);
    reg_wr(OFS_PORT_D_VALUE, 8'h2a);
    reg_wr(OFS_BUS_CTRL, 8'h01);
    reg_wr(OFS_PORT_G_DIRECTION, 8'h0f);
    reg_wr(OFS_PORT_G_VALUE, 8'h05);
    pause(1);
    chk({2'h0, pd_oe}, 8'h00);
    chk({2'h0, pd_o}, 8'h2b);
    reg_rd(OFS_PORT_D_DIRECTION, 8'h3f);
    chk(pg_oe, 8'h00);
    chk(pg_o, 8'ha5);
  endtask

  task automatic t_port_e();
    @(posedge clk_sys_i);
    pe <= 8'h5a;
    reg_wr(OFS_PORT_E_VALUE, 8'hff);
    reg_rd(OFS_PORT_E_VALUE, 8'h5a);
    reg_rd(16'h1030, 8'h00);
    reg_rd(OFS_BUS_STATUS, 8'h03);
  endtask

  task automatic t_ext_bus();
    ext_acc(1'b1, 16'h1234, 8'h5c, 8'h00, 1'b0);
    chk(pb, 8'h12);
    chk(pf, 8'h34);
    ext_acc(1'b0, 16'h1234, 8'h00, 8'h5c, 1'b1);
    @(posedge clk_sys_i);
    slow <= 1'b1;
    ext_acc(1'b1, 16'h0077, 8'hc3, 8'h00, 1'b0);
    ext_acc(1'b0, 16'h0077, 8'h00, 8'hc3, 1'b1);
    @(posedge clk_sys_i);
    slow <= 1'b0;
  endtask

  task automatic t_fail_instr();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys_i);
      cmf <= (i == 0);
      wdf <= (i == 1);
      @(posedge clk_sys_i);
      cmf <= 1'b0;
      wdf <= 1'b0;
      #1 chk({rp, rp_oe, 6'h00}, 8'h00);
      pause(5);
      chk({7'h00, rp_oe}, 8'h01);
    end
    @(posedge clk_sys_i);
    ins <= 1'b1;
    @(posedge clk_sys_i);
    ins <= 1'b0;
    #1 chk({6'h00, ip, ip_oe}, 8'h00);
    pause(4);
    chk({7'h00, ip_oe}, 8'h01);
  endtask

  task automatic t_single();
    reg_wr(OFS_PORT_B_VALUE, 8'h96);
    reg_wr(OFS_PORT_F_VALUE, 8'h69);
    reg_wr(OFS_PORT_C_DIRECTION, 8'hff);
    reg_wr(OFS_PORT_C_VALUE, 8'h33);
    pause(1);
    chk(pb, 8'h96);
    chk(pf, 8'h69);
    chk(pc_oe, 8'h00);
    chk(pc_o, 8'h33);
    ext_acc(1'b0, 16'h0034, 8'h00, 8'h00, 1'b1);
    chk(pb, 8'h96);
  endtask

  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    #50us;
    fails++;
    complete_run();
  end

  initial begin
    do_reset(1'b1, 1'b1);
    chk({6'h00, mode}, 8'h03);
    chk(pa_oe, 8'hff);
    t_port_a();
    t_ports_dg();
    t_port_e();
    t_ext_bus();
    t_fail_instr();
    do_reset(1'b1, 1'b0);
    chk({6'h00, mode}, 8'h02);
    t_single();
    complete_run();
  end
endmodule // ebp_bus_ports_tb
